// ### hdl/pmt_pkg.sv
// package: register map, field layout and reset values of the period match timer
package pmt_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  OFF_CONTROL     = 4'h0;
    localparam logic [3:0]  OFF_PERIOD      = 4'h1;
    localparam logic [3:0]  OFF_COUNT       = 4'h2;
    localparam logic [3:0]  OFF_INT_STATUS  = 4'h3;
    localparam logic [3:0]  OFF_INT_MASK    = 4'h4;
    localparam logic [3:0]  OFF_POST_COUNT  = 4'h5;
    localparam int          POST_LO         = 3;
    localparam int          POST_HI         = 6;
    localparam int          ON_BIT          = 2;
    localparam int          PRE_LO          = 0;
    localparam int          PRE_HI          = 1;
    localparam logic [7:0]  CONTROL_RST     = 8'h00;
    localparam logic [7:0]  CONTROL_WMASK   = 8'h7F;
    localparam logic [7:0]  PERIOD_RST      = 8'hFF;
    localparam logic [7:0]  COUNT_RST       = 8'h00;
    localparam logic [1:0]  PRE_DIV1        = 2'h0;
    localparam logic [1:0]  PRE_DIV4        = 2'h1;
    localparam logic [3:0]  PRE_LAST_DIV4   = 4'h3;
    localparam logic [3:0]  PRE_LAST_DIV16  = 4'hF;
    localparam int          IRQ_MATCH       = 0;
    localparam int          IRQ_POST        = 1;
    localparam logic [1:0]  IRQ_RST         = 2'h0;
endpackage

// ### hdl/pmt_prescaler.sv
// module: clock prescaler producing one-cycle tick pulses
module pmt_prescaler (
    input  wire logic       CLOCK,
    input  wire logic       RESET,
    input  wire logic       ENABLE,
    input  wire logic [1:0] SELECT,
    output logic            TICK
);
    import pmt_pkg::*;

    logic [3:0] pre_cnt_r;
    logic [3:0] last;

    // terminal count for the chosen ratio; code 1x means divide by 16
    always_comb begin
        case (SELECT)
            PRE_DIV1: last = 4'h0;
            PRE_DIV4: last = PRE_LAST_DIV4;
            default:  last = PRE_LAST_DIV16;
        endcase
    end

    // counter cleared while off so every start sees a full prescale period
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            pre_cnt_r <= 4'h0;
        end else if (!ENABLE || pre_cnt_r >= last) begin
            pre_cnt_r <= 4'h0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 4'h1;
        end
    end

    assign TICK = ENABLE && (pre_cnt_r >= last); // [R7]
endmodule // pmt_prescaler

// ### hdl/pmt_timer.sv
// module: 8-bit period match timer with prescaler, postscaler and register port
//
// Functional notes
// R1: control bits 6..3 select postscale 1:1 up to 1:16, code plus one.
// R2: 8-bit period register, readable and writable at any time.
// R3: when on, count advances per tick up to period, then wraps to 00h.
// R4: period register resets to FFh.
// R5: pre-postscaler match goes only to PWM compare modules as time base; here it also sets status bit 0.
// R6: match is not offered as serial port baud clock.
// R7: prescale bits 1..0 divide 1/4/16; bit 2 turns the timer on.
//
// register map, one 8-bit register per ADDR index:
//   0 control  bit 7 reads 0, bits 6..3 postscale code, bit 2 on, bits 1..0 prescale
//   1 period   match value, FFh after reset, may be rewritten while counting
//   2 count    live counter value, a write beats a tick in the same cycle
//   3 status   bit 0 match seen, bit 1 postscale seen; write one to clear
//   4 mask     same layout as status; IRQ is high while status and mask share a bit
//   5 postcnt  matches gathered toward the next postscale pulse, read only
//   other      reads return zero, writes are dropped
//
// timing:
//   a tick comes every 1, 4 or 16 clocks while the timer is on
//   the count steps 0, 1 .. period, then back to zero on the next tick
//   so the time base pulse repeats every (period + 1) * prescale clocks
//   and the postscale pulse every (code + 1) time base pulses
//   both pulses stand for one clock; postscale trails its match by one clock
//   read data stand for the one clock after the strobe and are zero otherwise
//   strobes may come back to back; every write lands on the edge it is taken
//
// trade-offs and limitations:
//   turning the timer off clears prescale and postscale progress but keeps
//   the count, so a restart resumes where it stopped
//   a period written below the live count lets the counter run up to FFh
//   and roll over before the next match, since only equality is compared
//   the match pulse is registered, which costs one clock of latency but
//   keeps the time base free of glitches for the pwm side
//   a clear and a new event in the same cycle leave the flag set, so no
//   event is ever lost to a late clear
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module pmt_timer (
    input  wire logic                       CLOCK,
    input  wire logic                       RESET,
    input  wire logic [pmt_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [pmt_pkg::DATA_W-1:0] WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    output logic      [pmt_pkg::DATA_W-1:0] RDATA,
    output logic                            PWM_TIME_BASE,
    output logic      [pmt_pkg::DATA_W-1:0] TIMER_COUNT,
    output logic                            POST_EVENT,
    output logic                            IRQ
);
    import pmt_pkg::*;

    // state held in flip-flops
    logic [7:0] control_r;
    logic [7:0] period_r;
    logic [7:0] count_r;
    logic [3:0] post_cnt_r;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic       match_r;
    logic       post_r;
    logic [7:0] rdata_r;

    // combinational helpers
    logic       tick;
    logic       timer_on;
    logic       at_period;
    logic       post_done;
    logic [1:0] events;
    logic [3:0] post_sel;
    logic       wr_control;
    logic       wr_period;
    logic       wr_count;
    logic       wr_status;
    logic       wr_mask;
    logic [7:0] rdata_nxt;

    assign timer_on  = control_r[ON_BIT];
    assign post_sel  = control_r[POST_HI:POST_LO];
    assign at_period = (count_r == period_r);

    // write decodes; an unmapped index matches none of them and is dropped
    assign wr_control = WR && (ADDR == OFF_CONTROL);
    assign wr_period  = WR && (ADDR == OFF_PERIOD);
    assign wr_count   = WR && (ADDR == OFF_COUNT);
    assign wr_status  = WR && (ADDR == OFF_INT_STATUS);
    assign wr_mask    = WR && (ADDR == OFF_INT_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // prescaler
    pmt_prescaler u_pre (
        .CLOCK  (CLOCK),
        .RESET  (RESET),
        .ENABLE (timer_on),
        .SELECT (control_r[PRE_HI:PRE_LO]),
        .TICK   (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // control register; bit 7 is unimplemented and reads zero
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            control_r <= CONTROL_RST;
        end else if (wr_control) begin
            control_r <= WDATA & CONTROL_WMASK; // [R1] [R7]
        end
    end

    // period register, writable at any time, even while counting
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            period_r <= PERIOD_RST; // [R4]
        end else if (wr_period) begin
            period_r <= WDATA; // [R2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter; a software write wins over a tick so the new value sticks
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            count_r <= COUNT_RST;
        end else if (wr_count) begin
            count_r <= WDATA;
        end else if (tick) begin
            count_r <= at_period ? COUNT_RST : count_r + 8'h01; // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // match pulse taken before the postscaler, one cycle per wrap
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            match_r <= 1'b0;
        end else begin
            match_r <= tick && at_period; // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // postscaler: counts matches, fires after post_sel+1 of them
    assign post_done = match_r && (post_cnt_r >= post_sel);

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            post_cnt_r <= 4'h0;
        end else if (!timer_on || post_done) begin
            post_cnt_r <= 4'h0;
        end else if (match_r) begin
            post_cnt_r <= post_cnt_r + 4'h1; // [R1]
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            post_r <= 1'b0;
        end else begin
            post_r <= post_done; // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, write one to clear, a new event wins
    assign events[IRQ_MATCH] = match_r;
    assign events[IRQ_POST]  = post_done;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            status_r <= IRQ_RST;
        end else if (wr_status) begin
            status_r <= (status_r & ~WDATA[1:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            mask_r <= IRQ_RST;
        end else if (wr_mask) begin
            mask_r <= WDATA[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; zero when idle so the bus can be or-ed with other slaves
    always_comb begin
        rdata_nxt = 8'h00;
        if (RD) begin
            case (ADDR)
                OFF_CONTROL:    rdata_nxt = control_r;
                OFF_PERIOD:     rdata_nxt = period_r; // [R2]
                OFF_COUNT:      rdata_nxt = count_r;
                OFF_INT_STATUS: rdata_nxt = {6'h00, status_r};
                OFF_INT_MASK:   rdata_nxt = {6'h00, mask_r};
                OFF_POST_COUNT: rdata_nxt = {4'h0, post_cnt_r};
                default:        rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data registered, valid only in the cycle after the strobe
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; data outputs come from flip-flops, the irq level from registers
    // the match reaches the pwm side and status bit 0; no baud clock output exists
    assign PWM_TIME_BASE = match_r; // [R5] [R6]
    assign TIMER_COUNT   = count_r;
    assign POST_EVENT    = post_r;
    assign RDATA         = rdata_r;
    assign IRQ           = |(status_r & mask_r);
endmodule // pmt_timer

// ### tb/pmt_timer_properties.sv
// checker: port timing relations of the period match timer
module pmt_timer_properties (
    input wire logic       CLOCK,
    input wire logic       RESET,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       PWM_TIME_BASE,
    input wire logic [7:0] TIMER_COUNT,
    input wire logic       POST_EVENT
);
    timeunit 1ns;
    timeprecision 100ps;
    import pmt_pkg::*;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////
    // counter falls to zero with no write behind it; a rollover from FFh
    // under a period below the count is legal and carries no match
    sequence wrap_s;
        !WR && TIMER_COUNT != 8'h00 && TIMER_COUNT != 8'hFF ##1 TIMER_COUNT == 8'h00;
    endsequence
    // period written, one quiet cycle, then read back
    sequence period_wr_s;
        WR && ADDR == OFF_PERIOD;
    endsequence
    sequence period_rd_s;
        !(WR && ADDR == OFF_PERIOD) ##1 RD && ADDR == OFF_PERIOD;
    endsequence
    chk_read_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside its cycle");
    chk_count_step: assert property ($changed(TIMER_COUNT) && !$past(WR) |->
        TIMER_COUNT == $past(TIMER_COUNT) + 8'h01 || TIMER_COUNT == 8'h00)
        else $error("counter skipped a value");
    chk_wrap_zero: assert property (PWM_TIME_BASE |-> TIMER_COUNT == 8'h00)
        else $error("time base pulse without wrap");
    chk_base_wrap: assert property (wrap_s |-> PWM_TIME_BASE)
        else $error("wrap without time base pulse");
    chk_post_after: assert property (POST_EVENT |-> $past(PWM_TIME_BASE))
        else $error("postscale pulse not after match");
    chk_period_back: assert property (period_wr_s ##1 period_rd_s |=>
        RDATA == $past(WDATA, 3))
        else $error("period read back differs from write");
endmodule // pmt_timer_properties

// ### tb/pmt_pwm_sink.sv
// partner: pwm compare module counting time base periods
module pmt_pwm_sink (
    input  wire logic       CLOCK,
    input  wire logic       RESET,
    input  wire logic       PWM_TIME_BASE,
    output logic      [7:0] periods_seen
);
    timeunit 1ns;
    timeprecision 100ps;

    // one pwm period starts per time base pulse
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) periods_seen <= 8'h00;
        else if (PWM_TIME_BASE) periods_seen <= periods_seen + 8'h01;
    end
endmodule // pmt_pwm_sink

// ### tb/pmt_timer_bench.sv
// bench: register, timing and interrupt scenarios of the timer
module pmt_timer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pmt_pkg::*;
    logic              CLOCK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, rd_q = 1'b0;
    logic [3:0]        ADDR = 4'h0;
    logic [7:0]        WDATA = 8'h00, RDATA, TIMER_COUNT, seen;
    logic              PWM_TIME_BASE, POST_EVENT, IRQ;
    logic [31:0]       seed = 32'h00013C69;
    logic [7:0]        expq[$];
    int                fail_count = 0, total_checks = 0, cycles = 0, n;
    pmt_timer i_pmt_timer (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .PWM_TIME_BASE(PWM_TIME_BASE),
        .TIMER_COUNT(TIMER_COUNT), .POST_EVENT(POST_EVENT), .IRQ(IRQ));
    pmt_pwm_sink i_pmt_pwm_sink (.CLOCK(CLOCK), .RESET(RESET),
        .PWM_TIME_BASE(PWM_TIME_BASE), .periods_seen(seen));
    ////////////////////////////////////////
    // 4 ns clock
    always #2 CLOCK = ~CLOCK;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobes drop for a cycle so no signal is set twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        ADDR <= a;
        RD <= 1'b1;
        expq.push_back(e);
        @(posedge CLOCK);
        RD <= 1'b0;
        @(posedge CLOCK);
    endtask
    // cycles from one pulse to the next, looked at mid-cycle where pulses stand
    task automatic gap(input bit post, output int k);
        do @(negedge CLOCK); while ((post ? POST_EVENT : PWM_TIME_BASE) !== 1'b1);
        k = 0;
        do begin
            @(negedge CLOCK);
            k++;
        end while ((post ? POST_EVENT : PWM_TIME_BASE) !== 1'b1);
        @(posedge CLOCK);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // read data watcher, oldest note first
    always @(posedge CLOCK) rd_q <= RD;
    always @(negedge CLOCK) if (rd_q) check(16'(RDATA), 16'(expq.pop_front()));
    // hang guard
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        rd(OFF_PERIOD, PERIOD_RST);
        rd(OFF_CONTROL, CONTROL_RST);
        rd(4'hF, 8'h00);
        seed = lfsr(seed);
        wr(OFF_PERIOD, seed[7:0]);
        rd(OFF_PERIOD, seed[7:0]);
        wr(OFF_PERIOD, 8'h03);
        for (int i = 0; i < 4; i++) begin
            int d;
            d = (i == 0) ? 1 : (i == 1) ? 4 : 16;
            wr(OFF_CONTROL, 8'h00);
            wr(OFF_COUNT, 8'h00);
            wr(OFF_CONTROL, {1'b0, 4'(i), 1'b1, 2'(i)});
            gap(1'b0, n);
            check(16'(n), 16'(4 * d));
            gap(1'b1, n);
            check(16'(n), 16'(4 * d * (i + 1)));
        end
        check(16'(IRQ), 16'h0000);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_COUNT, 8'h5A);
        check(16'(TIMER_COUNT), 16'h005A);
        rd(OFF_COUNT, 8'h5A);
        rd(OFF_POST_COUNT, 8'h00);
        rd(OFF_INT_STATUS, 8'h03);
        wr(OFF_INT_MASK, 8'h01);
        check(16'(IRQ), 16'h0001);
        wr(OFF_INT_STATUS, 8'h03);
        rd(OFF_INT_STATUS, 8'h00);
        check(16'(IRQ), 16'h0000);
        check(16'(seen == 8'h00), 16'h0000);
        wr(OFF_CONTROL, 8'hFF);
        rd(OFF_CONTROL, 8'h7F);
        close_out();
    end
endmodule // pmt_timer_bench
bind pmt_timer pmt_timer_properties i_pmt_timer_properties (.CLOCK(CLOCK),
    .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PWM_TIME_BASE(PWM_TIME_BASE),
    .TIMER_COUNT(TIMER_COUNT), .POST_EVENT(POST_EVENT));
